//--- hdl/sim_config_unit.sv
// Integration unit configuration registers, timers, monitors and acknowledge logic
`timescale 1ns/1ps
module sim_config_unit (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire sim_cfg_pkg::reg_sel_t wr_sel_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_user_i,
  input wire logic xtal_lost_i,
  input wire logic low_power_stop_instr_i,
  input wire logic freeze_i,
  input wire logic wd_service_i,
  input wire logic double_fault_i,
  input wire logic bus_cycle_i,
  input wire logic bus_done_i,
  input wire logic iack_i,
  input wire logic [2:0] iack_level_i,
  output logic [15:0] base_addr_o,
  output logic base_valid_o,
  output logic [11:0] synth_mult_o,
  output logic limp_mode_o,
  output logic sys_reset_req_o,
  output logic sysclk_run_o,
  output logic clock_output_pin_run_o,
  output logic boot_chip_select_en_o,
  output logic autovector_request_in_en_o,
  output logic [1:0] show_cycle_enable_o,
  output logic user_access_blocked_o,
  output logic [3:0] irq_arbitration_level_o,
  output logic [2:0] irq_level_o,
  output logic [7:0] iack_vector_o,
  output logic iack_vector_valid_o,
  output logic autovector_o,
  output logic halt_o,
  output logic bus_error_o,
  output logic [7:0] port_a_function_reg1_o,
  output logic [7:0] port_a_function_reg2_o,
  output logic [7:0] port_b_function_reg_o,
  output logic boot_port16_o,
  output logic [3:0] boot_wait_states_o
);

  // Register state and next values
  logic [15:0] base_reg, base_next; // Base address, bit 0 valid
  sim_cfg_pkg::synth_t synth_reg, synth_next; // Clock synthesizer control
  sim_cfg_pkg::mcr_t mcr_reg, mcr_next; // Module configuration
  logic [7:0] avr_reg, avr_next; // Autovector select per level
  sim_cfg_pkg::prot_t prot_reg, prot_next; // System protection
  logic prot_done_reg, prot_done_next; // Protection already written
  logic [7:0] watchdog_vector_reg_reg, watchdog_vector_reg_next; // Watchdog vector
  sim_cfg_pkg::periodic_timer_reg_t periodic_timer_reg_reg, periodic_timer_reg_next; // Periodic timer
  sim_cfg_pkg::periodic_irq_control_reg_t periodic_irq_control_reg_reg, periodic_irq_control_reg_next; // Periodic interrupt control
  logic [7:0] pa1_reg, pa1_next, pa2_reg, pa2_next, pb_reg, pb_next; // Pin functions
  sim_cfg_pkg::boot_t boot_reg, boot_next; // Boot chip-select option
  logic wr_ok; // Write accepted

  // Event state and next values
  logic wd_pend_reg, wd_pend_next; // Watchdog interrupt pending
  logic pit_pend_reg, pit_pend_next; // Periodic interrupt pending
  logic lost_reg, lost_next; // Crystal loss already seen
  logic rst_req_next, limp_next, halt_next;
  logic [7:0] vec_next;
  logic vec_valid_next, autovector_request_in_next;
  logic wd_expire, pit_expire; // Timer expiry pulses
  logic [15:0] wd_period;
  logic wd_ack, pit_ack;

  // Register writes: blocked until relocated and for user mode when restricted
  always_comb
  begin
    wr_ok = wr_en_i && (base_reg[0] || wr_sel_i == sim_cfg_pkg::SEL_BASE);
    if (wr_user_i && mcr_reg.privilege_select_bit)
      wr_ok = 1'b0;
    base_next = base_reg;
    synth_next = synth_reg;
    mcr_next = mcr_reg;
    avr_next = avr_reg;
    prot_next = prot_reg;
    prot_done_next = prot_done_reg;
    watchdog_vector_reg_next = watchdog_vector_reg_reg;
    periodic_timer_reg_next = periodic_timer_reg_reg;
    periodic_irq_control_reg_next = periodic_irq_control_reg_reg;
    pa1_next = pa1_reg;
    pa2_next = pa2_reg;
    pb_next = pb_reg;
    boot_next = boot_reg;
    // Untouched registers simply hold their current contents
    if (wr_ok)
    begin
      case (wr_sel_i)
        sim_cfg_pkg::SEL_BASE: base_next = wr_data_i;
        sim_cfg_pkg::SEL_SYNTH: synth_next = sim_cfg_pkg::synth_t'(wr_data_i);
        sim_cfg_pkg::SEL_MCR: mcr_next = sim_cfg_pkg::mcr_t'(wr_data_i);
        sim_cfg_pkg::SEL_AVR: avr_next = {wr_data_i[7:1], 1'b0};
        sim_cfg_pkg::SEL_PROT:
        begin
          // A second write is dropped without any error indication
          if (!prot_done_reg)
          begin
            prot_next = sim_cfg_pkg::prot_t'(wr_data_i[7:0]);
            prot_done_next = 1'b1;
          end
        end
        sim_cfg_pkg::SEL_WATCHDOG_VECTOR_REG: watchdog_vector_reg_next = wr_data_i[7:0];
        sim_cfg_pkg::SEL_PERIODIC_TIMER_REG: periodic_timer_reg_next = sim_cfg_pkg::periodic_timer_reg_t'(wr_data_i);
        sim_cfg_pkg::SEL_PERIODIC_IRQ_CONTROL_REG: periodic_irq_control_reg_next = sim_cfg_pkg::periodic_irq_control_reg_t'(wr_data_i);
        sim_cfg_pkg::SEL_PA1: pa1_next = wr_data_i[7:0];
        sim_cfg_pkg::SEL_PA2: pa2_next = wr_data_i[7:0];
        sim_cfg_pkg::SEL_PB: pb_next = wr_data_i[7:0];
        sim_cfg_pkg::SEL_BOOT: boot_next = sim_cfg_pkg::boot_t'(wr_data_i[7:0]);
        default: base_next = base_reg;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      base_reg <= sim_cfg_pkg::BASE_RST;
      synth_reg <= sim_cfg_pkg::synth_t'(sim_cfg_pkg::SYNTH_RST);
      mcr_reg <= sim_cfg_pkg::mcr_t'(sim_cfg_pkg::MCR_RST);
      avr_reg <= sim_cfg_pkg::AVR_RST;
      prot_reg <= sim_cfg_pkg::prot_t'(sim_cfg_pkg::PROT_RST);
      prot_done_reg <= 1'b0;
      watchdog_vector_reg_reg <= sim_cfg_pkg::WATCHDOG_VECTOR_REG_RST;
      periodic_timer_reg_reg <= sim_cfg_pkg::periodic_timer_reg_t'(sim_cfg_pkg::PERIODIC_TIMER_REG_RST);
      periodic_irq_control_reg_reg <= sim_cfg_pkg::periodic_irq_control_reg_t'(sim_cfg_pkg::PERIODIC_IRQ_CONTROL_REG_RST);
      pa1_reg <= sim_cfg_pkg::PORT_RST;
      pa2_reg <= sim_cfg_pkg::PORT_RST;
      pb_reg <= sim_cfg_pkg::PORT_RST;
      boot_reg <= sim_cfg_pkg::boot_t'(sim_cfg_pkg::BOOT_RST);
    end
    else if (ce_i)
    begin
      base_reg <= base_next;
      synth_reg <= synth_next;
      mcr_reg <= mcr_next;
      avr_reg <= avr_next;
      prot_reg <= prot_next;
      prot_done_reg <= prot_done_next;
      watchdog_vector_reg_reg <= watchdog_vector_reg_next;
      periodic_timer_reg_reg <= periodic_timer_reg_next;
      periodic_irq_control_reg_reg <= periodic_irq_control_reg_next;
      pa1_reg <= pa1_next;
      pa2_reg <= pa2_next;
      pb_reg <= pb_next;
      boot_reg <= boot_next;
    end
  end

  // Watchdog period grows fourfold per step of the timing field
  assign wd_period = sim_cfg_pkg::WD_BASE << {prot_reg.watchdog_timing_field, 1'b0};

  // Watchdog timer, held while frozen if so configured
  sim_down_timer u_watchdog (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(prot_reg.watchdog_enable_bit),
    .hold_i(freeze_i && mcr_reg.halt_response_bits[1]),
    .prescale_i(periodic_timer_reg_reg.watchdog_prescale_bit),
    .restart_i(wd_service_i),
    .period_i(wd_period),
    .expire_o(wd_expire)
  );

  // Periodic timer; a zero count keeps it stopped
  sim_down_timer u_periodic (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(periodic_timer_reg_reg.count != 8'h00),
    .hold_i(freeze_i && mcr_reg.halt_response_bits[0]),
    .prescale_i(periodic_timer_reg_reg.periodic_prescale_bit),
    .restart_i(1'b0),
    .period_i({8'h00, periodic_timer_reg_reg.count}),
    .expire_o(pit_expire)
  );

  // External bus monitor
  sim_bus_watch u_bus_watch (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .enable_i(prot_reg.bus_monitor_enable),
    .cycle_i(bus_cycle_i),
    .done_i(bus_done_i),
    .timing_i(prot_reg.bus_monitor_timing),
    .bus_error_o(bus_error_o)
  );

  // Interrupt level presented: watchdog at level 7 wins over periodic
  always_comb
  begin
    if (wd_pend_reg)
      irq_level_o = sim_cfg_pkg::WD_IRQ_LEVEL;
    else if (pit_pend_reg)
      irq_level_o = periodic_irq_control_reg_reg.periodic_irq_level;
    else
      irq_level_o = 3'h0;
  end

  // Event logic: pending flags, acknowledge answers, resets and limp mode
  always_comb
  begin
    wd_ack = iack_i && wd_pend_reg && iack_level_i == sim_cfg_pkg::WD_IRQ_LEVEL;
    pit_ack = iack_i && pit_pend_reg && !wd_ack && iack_level_i == periodic_irq_control_reg_reg.periodic_irq_level;
    // New expiry in the acknowledge cycle keeps the flag set
    wd_pend_next = (wd_pend_reg && !wd_ack)
                 || (wd_expire && !prot_reg.watchdog_reset_or_irq);
    pit_pend_next = (pit_pend_reg && !pit_ack) || pit_expire;
    vec_next = iack_vector_o;
    vec_valid_next = 1'b0;
    autovector_request_in_next = 1'b0;
    if (wd_ack)
    begin
      vec_next = watchdog_vector_reg_reg;
      vec_valid_next = 1'b1;
    end
    else if (pit_ack)
    begin
      vec_next = periodic_irq_control_reg_reg.vector;
      vec_valid_next = 1'b1;
    end
    else if (iack_i && avr_reg[iack_level_i])
      autovector_request_in_next = 1'b1;
    lost_next = xtal_lost_i;
    rst_req_next = (wd_expire && prot_reg.watchdog_reset_or_irq)
                 || (xtal_lost_i && !lost_reg && synth_reg.loss_of_ref_reset_en);
    limp_next = xtal_lost_i && !synth_reg.loss_of_ref_reset_en;
    halt_next = double_fault_i && prot_reg.double_fault_monitor_en;
  end

  // Event registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wd_pend_reg <= 1'b0;
      pit_pend_reg <= 1'b0;
      lost_reg <= 1'b0;
      iack_vector_o <= 8'h00;
      iack_vector_valid_o <= 1'b0;
      autovector_o <= 1'b0;
      sys_reset_req_o <= 1'b0;
      limp_mode_o <= 1'b0;
      halt_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wd_pend_reg <= wd_pend_next;
      pit_pend_reg <= pit_pend_next;
      lost_reg <= lost_next;
      iack_vector_o <= vec_next;
      iack_vector_valid_o <= vec_valid_next;
      autovector_o <= autovector_request_in_next;
      sys_reset_req_o <= rst_req_next;
      limp_mode_o <= limp_next;
      halt_o <= halt_next;
    end
  end

  // Configuration seen by the rest of the chip
  assign base_addr_o = {base_reg[15:1], 1'b0};
  assign base_valid_o = base_reg[0];
  // Multiplier 4*(y+1) scaled by 4 for w and 2 for x
  assign synth_mult_o = {3'h0, synth_reg.y + 7'h01, 2'h0}
                        << {synth_reg.w, synth_reg.x};
  assign sysclk_run_o = !low_power_stop_instr_i || synth_reg.stop_sysclk_keep;
  assign clock_output_pin_run_o = !low_power_stop_instr_i || synth_reg.stop_clock_output_pin_keep;
  assign boot_chip_select_en_o = !mcr_reg.cs0_autovector_request_in;
  assign autovector_request_in_en_o = mcr_reg.cs0_autovector_request_in;
  assign show_cycle_enable_o = mcr_reg.show_cycle_enable;
  assign user_access_blocked_o = mcr_reg.privilege_select_bit;
  assign irq_arbitration_level_o = mcr_reg.irq_arbitration_level;
  assign port_a_function_reg1_o = pa1_reg;
  assign port_a_function_reg2_o = pa2_reg;
  assign port_b_function_reg_o = pb_reg;
  assign boot_port16_o = boot_reg.port16;
  assign boot_wait_states_o = boot_reg.wait_states;

  property p_prot_once;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && prot_done_reg) |=> $stable(prot_reg);
  endproperty
  a_prot_once: assert property (p_prot_once) else $error("protection changed after first write");

  property p_autovector_request_in;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && iack_i && !wd_ack && !pit_ack && avr_reg[iack_level_i]) |=> autovector_o;
  endproperty
  a_autovector_request_in: assert property (p_autovector_request_in) else $error("autovector missing");

  property p_wd_vec;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && wd_ack) |=> (iack_vector_valid_o && iack_vector_o == $past(watchdog_vector_reg_reg));
  endproperty
  a_wd_vec: assert property (p_wd_vec) else $error("wrong watchdog vector");

  property p_wd_reset;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && wd_expire) |=> (prot_reg.watchdog_reset_or_irq ? sys_reset_req_o
                                                             : irq_level_o == 3'h7);
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog timeout action wrong");

  property p_limp;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && xtal_lost_i && !synth_reg.loss_of_ref_reset_en) |=> limp_mode_o;
  endproperty
  a_limp: assert property (p_limp) else $error("limp mode not entered");

  property p_stop_clk;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (low_power_stop_instr_i && !synth_reg.stop_sysclk_keep) |-> !sysclk_run_o;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("system clock kept in stop");

  property p_user_block;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && wr_en_i && wr_user_i && mcr_reg.privilege_select_bit) |=> $stable(mcr_reg);
  endproperty
  a_user_block: assert property (p_user_block) else $error("user write accepted");

  property p_halt;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !prot_reg.double_fault_monitor_en) |=> !halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt while monitor disabled");

endmodule

//--- hdl/sim_cfg_pkg.sv
// Shared selects, field layouts, reset values and timing counts of the integration unit
package sim_cfg_pkg;

  // Register selected by the configuration write port
  typedef enum logic [3:0] {
    SEL_BASE, SEL_SYNTH, SEL_MCR, SEL_AVR, SEL_PROT, SEL_WATCHDOG_VECTOR_REG,
    SEL_PERIODIC_TIMER_REG, SEL_PERIODIC_IRQ_CONTROL_REG, SEL_PA1, SEL_PA2, SEL_PB, SEL_BOOT
  } reg_sel_t;

  // Clock synthesizer control layout
  typedef struct packed {
    logic w;
    logic x;
    logic [5:0] y;
    logic [3:0] rsvd;
    logic loss_of_ref_reset_en;
    logic stop_sysclk_keep;
    logic stop_clock_output_pin_keep;
    logic rsvd0;
  } synth_t;

  // Module configuration layout
  typedef struct packed {
    logic rsvd15;
    logic [1:0] halt_response_bits;
    logic cs0_autovector_request_in;
    logic [1:0] rsvd;
    logic [1:0] show_cycle_enable;
    logic privilege_select_bit;
    logic [2:0] rsvd2;
    logic [3:0] irq_arbitration_level;
  } mcr_t;

  // System protection layout
  typedef struct packed {
    logic watchdog_enable_bit;
    logic watchdog_reset_or_irq;
    logic [1:0] watchdog_timing_field;
    logic double_fault_monitor_en;
    logic bus_monitor_enable;
    logic [1:0] bus_monitor_timing;
  } prot_t;

  // Periodic timer layout
  typedef struct packed {
    logic [5:0] rsvd;
    logic watchdog_prescale_bit;
    logic periodic_prescale_bit;
    logic [7:0] count;
  } periodic_timer_reg_t;

  // Periodic interrupt control layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] periodic_irq_level;
    logic [7:0] vector;
  } periodic_irq_control_reg_t;

  // Boot chip-select option layout
  typedef struct packed {
    logic [2:0] rsvd;
    logic port16;
    logic [3:0] wait_states;
  } boot_t;

  // Reset values
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] SYNTH_RST = 16'h3F00;
  localparam logic [15:0] MCR_RST = 16'h0080;
  localparam logic [7:0] AVR_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_VECTOR_REG_RST = 8'h0F;
  localparam logic [15:0] PERIODIC_TIMER_REG_RST = 16'h0000;
  localparam logic [15:0] PERIODIC_IRQ_CONTROL_REG_RST = 16'h000F;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] BOOT_RST = 8'h13;

  // Timing counts and watchdog interrupt level
  localparam int PRESCALE_W = 9;
  localparam logic [15:0] WD_BASE = 16'h0200;
  localparam logic [7:0] BM_BASE = 8'h40;
  localparam logic [2:0] WD_IRQ_LEVEL = 3'h7;

endpackage

//--- hdl/sim_down_timer.sv
// Prescaled reloading down-counter shared by watchdog and periodic timer
`timescale 1ns/1ps
module sim_down_timer (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic hold_i,
  input wire logic prescale_i,
  input wire logic restart_i,
  input wire logic [15:0] period_i,
  output logic expire_o
);

  logic [sim_cfg_pkg::PRESCALE_W-1:0] pre_reg; // Prescaler phase
  logic [sim_cfg_pkg::PRESCALE_W-1:0] pre_next;
  logic [15:0] cnt_reg; // Remaining ticks
  logic [15:0] cnt_next;
  logic exp_next;
  logic tick;
  logic armed_reg; // Period loaded since the timer last started
  logic armed_next;

  // Next state: a stopped timer reloads so it starts a full period later
  always_comb
  begin
    tick = run_i && !hold_i && (!prescale_i || (&pre_reg));
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    armed_next = run_i;
    // A timer that just started loads the period written with its start, not a stale one
    if (!run_i || restart_i || !armed_reg)
    begin
      pre_next = '0;
      cnt_next = period_i;
    end
    else if (!hold_i)
    begin
      // Frozen timer keeps its phase
      pre_next = pre_reg + 1'b1;
      if (tick)
      begin
        if (cnt_reg <= 16'h0001)
        begin
          cnt_next = period_i;
          exp_next = 1'b1;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pre_reg <= '0;
      armed_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      expire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pre_reg <= pre_next;
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      expire_o <= exp_next;
    end
  end

  property p_stop_quiet;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && (!run_i || hold_i)) |=> !expire_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("timer expired while stopped");

  property p_reload;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && run_i && armed_reg && !restart_i && !hold_i && tick && cnt_reg <= 16'h0001)
      |=> (expire_o && cnt_reg == $past(period_i));
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not expire and reload");

endmodule

//--- hdl/sim_bus_watch.sv
// External bus monitor: flags a cycle left unacknowledged too long
`timescale 1ns/1ps
module sim_bus_watch (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic cycle_i,
  input wire logic done_i,
  input wire logic [1:0] timing_i,
  output logic bus_error_o
);

  logic [7:0] cnt_reg; // Cycles the bus cycle has been open
  logic [7:0] cnt_next;
  logic err_next;
  logic [7:0] limit;

  // Limit halves per step of the timing field
  always_comb
  begin
    limit = sim_cfg_pkg::BM_BASE >> timing_i;
    cnt_next = 8'h00;
    err_next = 1'b0;
    if (enable_i && cycle_i && !done_i)
    begin
      cnt_next = cnt_reg + 8'h01;
      err_next = (cnt_next == limit);
    end
  end

  // Registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg <= 8'h00;
      bus_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_reg <= cnt_next;
      bus_error_o <= err_next;
    end
  end

  property p_bm_off;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !enable_i) |=> !bus_error_o;
  endproperty
  a_bm_off: assert property (p_bm_off) else $error("bus monitor fired while disabled");

endmodule

//--- bench/system_integration_setup_bench.sv
// Self-checking bench for the integration unit configuration logic
`timescale 1ns/1ps
module system_integration_setup_bench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic wr_en_i = 1'b0;
  sim_cfg_pkg::reg_sel_t wr_sel_i = sim_cfg_pkg::SEL_BASE;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_user_i = 1'b0;
  logic xtal_lost_i = 1'b0;
  logic low_power_stop_instr_i = 1'b0;
  logic freeze_i = 1'b0;
  logic wd_service_i = 1'b0;
  logic double_fault_i = 1'b0;
  logic bus_cycle_i = 1'b0;
  logic bus_done_i = 1'b0;
  logic iack_i = 1'b0;
  logic [2:0] iack_level_i = 3'h0;
  logic [15:0] base_addr_o;
  logic base_valid_o, limp_mode_o, sys_reset_req_o, sysclk_run_o, clock_output_pin_run_o;
  logic [11:0] synth_mult_o;
  logic boot_chip_select_en_o, autovector_request_in_en_o, user_access_blocked_o;
  logic [1:0] show_cycle_enable_o;
  logic [3:0] irq_arbitration_level_o, boot_wait_states_o;
  logic [2:0] irq_level_o;
  logic [7:0] iack_vector_o, port_a_function_reg1_o, port_a_function_reg2_o;
  logic [7:0] port_b_function_reg_o;
  logic iack_vector_valid_o, autovector_o, halt_o, bus_error_o, boot_port16_o;
  // Behavioural register image; a refused write never reaches it
  int mreg[12] = '{0, 'h3F00, 'h80, 0, 0, 'h0F, 0, 'h0F, 0, 0, 0, 'h13};
  bit prot_done = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int sd;

  sim_config_unit u_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .wr_en_i(wr_en_i),
    .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .wr_user_i(wr_user_i),
    .xtal_lost_i(xtal_lost_i), .low_power_stop_instr_i(low_power_stop_instr_i),
    .freeze_i(freeze_i), .wd_service_i(wd_service_i), .double_fault_i(double_fault_i),
    .bus_cycle_i(bus_cycle_i), .bus_done_i(bus_done_i), .iack_i(iack_i),
    .iack_level_i(iack_level_i), .base_addr_o(base_addr_o), .base_valid_o(base_valid_o),
    .synth_mult_o(synth_mult_o), .limp_mode_o(limp_mode_o),
    .sys_reset_req_o(sys_reset_req_o), .sysclk_run_o(sysclk_run_o),
    .clock_output_pin_run_o(clock_output_pin_run_o),
    .boot_chip_select_en_o(boot_chip_select_en_o),
    .autovector_request_in_en_o(autovector_request_in_en_o),
    .show_cycle_enable_o(show_cycle_enable_o), .user_access_blocked_o(user_access_blocked_o),
    .irq_arbitration_level_o(irq_arbitration_level_o), .irq_level_o(irq_level_o),
    .iack_vector_o(iack_vector_o), .iack_vector_valid_o(iack_vector_valid_o),
    .autovector_o(autovector_o), .halt_o(halt_o), .bus_error_o(bus_error_o),
    .port_a_function_reg1_o(port_a_function_reg1_o),
    .port_a_function_reg2_o(port_a_function_reg2_o),
    .port_b_function_reg_o(port_b_function_reg_o), .boot_port16_o(boot_port16_o),
    .boot_wait_states_o(boot_wait_states_o)
  );

  // Free-running 200 MHz clock
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Hang guard: the whole sequence needs well under 8000 cycles
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      conclude();
    end
  end

  // Value comparison against the model
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Delay comparison; a small margin covers the designer's pipeline stages
  task automatic chk_win(input string nm, input int nom, input int got);
    n_compared++;
    if (got < nom - 2 || got > nom + 3)
    begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, nom, got);
    end
  endtask

  // One write cycle; the model applies the same acceptance rules
  task automatic wr(input int sel, input int d, input logic u);
    @(posedge mclk_i);
    wr_en_i <= 1'b1;
    wr_sel_i <= sim_cfg_pkg::reg_sel_t'(sel);
    wr_data_i <= d[15:0];
    wr_user_i <= u;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
    wr_user_i <= 1'b0;
    if ((sel == 0 || mreg[0][0]) && !(u && mreg[2][7]))
    begin
      if (sel == 4)
      begin
        if (!prot_done)
          mreg[4] = d & 'hFF;
        prot_done = 1'b1;
      end
      else
        mreg[sel] = (sel == 3) ? (d & 'hFE) : d;
    end
    #1;
  endtask

  // Every register-driven output against the model
  task automatic chk_regs;
    logic [15:0] s;
    logic [15:0] m;
    s = mreg[1][15:0];
    m = mreg[2][15:0];
    chk("base", mreg[0] & 'hFFFE, base_addr_o);
    chk("valid", mreg[0] & 1, base_valid_o);
    chk("mult", ((s[13:8] + 16'h1) * 16'h4) << (2 * s[15] + s[14]), synth_mult_o);
    chk("sysclk", !low_power_stop_instr_i | s[2], sysclk_run_o);
    chk("clock_output_pin", !low_power_stop_instr_i | s[1], clock_output_pin_run_o);
    chk("cs0", {!m[12], m[12]}, {boot_chip_select_en_o, autovector_request_in_en_o});
    chk("show", m[9:8], show_cycle_enable_o);
    chk("priv", m[7], user_access_blocked_o);
    chk("arb", m[3:0], irq_arbitration_level_o);
    chk("pa1", mreg[8] & 'hFF, port_a_function_reg1_o);
    chk("pa2", mreg[9] & 'hFF, port_a_function_reg2_o);
    chk("pb", mreg[10] & 'hFF, port_b_function_reg_o);
    chk("boot", {mreg[11][4], mreg[11][3:0]}, {boot_port16_o, boot_wait_states_o});
  endtask

  // Count cycles until an event shows, bounded
  task automatic wait_n(input int w, input int lim, output int k);
    for (k = 1; k < lim; k++)
    begin
      @(posedge mclk_i);
      #1;
      if ((w == 0 && bus_error_o === 1'b1) || (w == 1 && irq_level_o === 3'h7)
          || (w == 2 && irq_level_o === 3'h3) || (w == 3 && sys_reset_req_o === 1'b1))
        break;
    end
  endtask

  // Acknowledge one level and check the one-cycle answer
  task automatic ack(input logic [2:0] lvl, input logic vv, input int vec, input logic av);
    @(posedge mclk_i);
    iack_i <= 1'b1;
    iack_level_i <= lvl;
    @(posedge mclk_i);
    iack_i <= 1'b0;
    #1;
    chk("vvalid", vv, iack_vector_valid_o);
    if (vv)
      chk("vector", vec & 'hFF, iack_vector_o);
    chk("autovec", av, autovector_o);
  endtask

  // Watchdog service pulse
  task automatic service;
    @(posedge mclk_i);
    wd_service_i <= 1'b1;
    @(posedge mclk_i);
    wd_service_i <= 1'b0;
  endtask

  // Final report and verdict
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    sd = $urandom(32'h575b724a);
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1;
    chk_regs();
    wr(8, $urandom, 1'b0);
    chk_regs();
    wr(0, $urandom | 1, 1'b0);
    // Every multiplier range, stop modes toggled
    for (int i = 0; i < 4; i++)
    begin
      low_power_stop_instr_i <= i[0];
      wr(1, {i[1:0], 6'($urandom_range(63, 0)), 8'h0} | (i * 2), 1'b0);
      chk_regs();
    end
    low_power_stop_instr_i <= 1'b0;
    // Both halt bits set, privilege set, chip-select choice, show and level random
    wr(2, {3'h3, 1'($urandom_range(1, 0)), 2'h0, 2'($urandom_range(3, 0)), 4'h8,
           4'($urandom_range(15, 0))}, 0);
    wr(9, $urandom, 1'b1);
    wr(8, $urandom, 1'b0);
    wr(10, $urandom, 1'b0);
    wr(11, $urandom & 'h1F, 1'b0);
    chk_regs();
    wr(5, $urandom, 1'b0);
    wr(7, 'h0300 | $urandom_range(255, 0), 1'b0);
    wr(4, 'h8C, 1'b0);
    wr(4, 'h00, 1'b0);
    bus_cycle_i <= 1'b1;
    // Clock enable low must hold the open-cycle count
    ce_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    ce_i <= 1'b1;
    wait_n(0, 200, n);
    chk_win("busmon", 64, n);
    bus_cycle_i <= 1'b0;
    double_fault_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("halt", 1, halt_o);
    double_fault_i <= 1'b0;
    service();
    wait_n(1, 700, n);
    chk_win("wdog", 514, n);
    ack(3'h7, 1'b1, mreg[5], 1'b0);
    service();
    freeze_i <= 1'b1;
    repeat (600) @(posedge mclk_i);
    #1;
    chk("frozen", 0, irq_level_o);
    freeze_i <= 1'b0;
    wait_n(1, 700, n);
    chk_win("wdthaw", 514, n);
    ack(3'h7, 1'b1, mreg[5], 1'b0);
    service();
    wr(6, 20, 1'b0);
    wait_n(2, 100, n);
    chk_win("periodic", 22, n);
    ack(3'h3, 1'b1, mreg[7], 1'b0);
    wr(6, 0, 1'b0);
    // Both prescalers on, count one: one tick per prescaler wrap
    wr(6, 'h0301, 1'b0);
    wait_n(2, 600, n);
    chk_win("prescale", (1 << sim_cfg_pkg::PRESCALE_W) + 2, n);
    ack(3'h3, 1'b1, mreg[7], 1'b0);
    wr(6, 0, 1'b0);
    wr(3, $urandom, 1'b0);
    for (int l = 1; l < 8; l++)
      ack(l[2:0], 1'b0, 0, mreg[3][l]);
    wr(2, mreg[2] & 'hFF7F, 1'b1);
    wr(2, mreg[2] & 'hFF7F, 1'b0);
    wr(10, $urandom, 1'b1);
    chk_regs();
    xtal_lost_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("limp", 1, limp_mode_o);
    xtal_lost_i <= 1'b0;
    wr(1, mreg[1] | 8, 1'b0);
    xtal_lost_i <= 1'b1;
    wait_n(3, 5, n);
    chk_win("lossrst", 1, n);
    conclude();
  end
endmodule
